// ### hw/err_cnt_defines.svh
// Offsets, field positions, reset values and period counts of the error counters.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef ERR_CNT_DEFINES_SVH
`define ERR_CNT_DEFINES_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_CFG        8'h41
`define IDX_LINE_HIGH  8'h42
`define IDX_LINE_LOW   8'h43
`define IDX_PATH_HIGH  8'h44
`define IDX_PATH_LOW   8'h45
`define IDX_OOS_HIGH   8'h46
`define IDX_OOS_LOW    8'h47

// ==========================================================================
// Configuration fields and reset
`define CFG_RESET      8'h00
`define CFG_WR_MASK    8'h7F
`define BIT_XZ_SEL     0
`define BIT_OOS_KIND   1
`define BIT_FS_EN      2
`define BIT_VIOL_KIND  3
`define BIT_ACC_MODE   4
`define BIT_PERIOD     5
`define BIT_MANUAL     6

// ==========================================================================
// Counts and periods (periods in received frames)
`define CNT_RESET      16'h0000
`define CNT_MAX        16'hFFFF
`define T1_SHORT_FRAMES 14'd333
`define E1_SHORT_FRAMES 14'd500
`define ONE_SEC_FRAMES 8000
`define ZRUN_NO_SUBST  5'd16
`define ZRUN_SUBST     5'd8

`endif

// ### hw/err_cnt_pkg.sv
// Types shared by the error counter block.
// Assumes the defines header supplies all numeric constants.
package err_cnt_pkg;

    // ======================================================================
    // Configuration register fields, bit 7 first
    typedef struct packed {
        logic unused;
        logic manual_latch_request;
        logic update_period_select;
        logic accumulation_mode_select;
        logic e1_violation_kind_select;
        logic fs_error_report_enable;
        logic oos_count_kind_select;
        logic excess_zero_count_select;
    } cfg_s;

    // Framer sync and mode levels
    typedef struct packed {
        logic e1_mode;
        logic esf_mode;
        logic zero_subst_enable;
        logic receive_sync_lost;
        logic fas_sync_lost;
        logic crc4_mf_sync_lost;
        logic fas_search;
    } rx_state_s;

    // Counter slots
    typedef enum logic [1:0] {
        CNT_LINE = 2'b00,
        CNT_PATH = 2'b01,
        CNT_OOS  = 2'b10
    } cnt_idx_e;

endpackage : err_cnt_pkg

// ### hw/line_path_error_counters.sv
// Line, path and out-of-sync error counters with APB register access.
// Assumes framer strobes are one-cycle pulses synchronous to pclk.
//
// Notes on behaviour
// - E1 line counter counts BPVs with kind bit 0, CVs with 1.
// - Mode bit 0 uses periodic select; mode bit 1 uses manual latch bit.
// - T1 latches every second, or every 333 frames with period bit set.
// - E1 latches every second, or every 500 frames with period bit set.
// - Manual bit rising latches counts next cycle; counters restart from any coincident event.
// - T1 line counter: BPVs, optional zeros, skips B8ZS words, ignores sync.
// - T1 excess zeros: 16 zeros without B8ZS, 8 zeros with it.
// - E1 BPVs are same-polarity marks, HDB3 words excluded when enabled.
// - E1 code violation is consecutive BPVs of the same polarity.
// - E1 line counter counts regardless of sync, saturates at 65535.
// - Count shown as high byte at lower address, low byte next.
// - T1 path counts CRC6 in ESF; Ft, plus Fs if enabled, in D4.
// - T1 path counter pauses while receive sync is lost.
// - E1 path counts CRC-4 errors, pauses on FAS or CRC-4 loss only.
// - T1 multiframe mode counts multiframes out of sync, runs during loss.
// - T1 F-bit mode counts Ft or FPS errors, pauses during sync loss.
// - E1 out-of-sync counter counts FAS word errors, off during sync loss.
// - E1 FAS errors not counted while searching for alignment.
// - All counters hold at maximum instead of wrapping.
// - In T1, out-of-sync kind bit 1 counts multiframes, 0 framing-bit errors.
`timescale 1ns/1ps
`include "err_cnt_defines.svh"

module line_path_error_counters
    import err_cnt_pkg::*;
#(
    parameter int SEC_FRAMES = `ONE_SEC_FRAMES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Receive framer levels
    input  wire rx_state_s   rx_state,
    // Receive framer strobes
    input  wire logic        frame_tick,
    input  wire logic        multiframe_tick,
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit_mark,
    input  wire logic        bpv_strobe,
    input  wire logic        bpv_polarity,
    input  wire logic        subst_codeword,
    input  wire logic        crc_error,
    input  wire logic        ft_error,
    input  wire logic        fs_error,
    input  wire logic        fps_error,
    input  wire logic        fas_word_error,
    // Status
    output logic             latch_pulse
);

    // ======================================================================
    // State
    cfg_s        cfg_reg;
    logic        manual_prev_reg;
    logic [4:0]  zrun_reg;
    logic        last_pol_reg;
    logic        last_valid_reg;
    logic [13:0] frame_cnt_reg;
    logic [15:0] cnt_reg  [3];
    logic [15:0] held_reg [3];
    logic [2:0]  ev;
    logic        manual_go;
    logic        periodic_go;
    logic        latch_now;
    logic [13:0] period;
    logic [4:0]  zrun_limit;
    logic        zrun_ev;
    logic        bpv_ok;
    logic        cv_ev;
    logic        e1;
    logic        sync_lost;

    assign e1        = rx_state.e1_mode;
    assign sync_lost = rx_state.receive_sync_lost;

    // ======================================================================
    // APB access
    logic       acc;
    logic [7:0] idx;
    logic [7:0] rd_byte;
    logic       hit;

    assign acc    = psel & penable;
    assign idx    = paddr[9:2];
    assign pready = 1'b1;

    // Read mux; high byte sits at the lower index
    always_comb begin
        rd_byte = 8'h00;
        hit     = 1'b1;
        case (idx)
            `IDX_CFG:       rd_byte = cfg_reg & `CFG_WR_MASK;
            `IDX_LINE_HIGH: rd_byte = held_reg[CNT_LINE][15:8];
            `IDX_LINE_LOW:  rd_byte = held_reg[CNT_LINE][7:0];
            `IDX_PATH_HIGH: rd_byte = held_reg[CNT_PATH][15:8];
            `IDX_PATH_LOW:  rd_byte = held_reg[CNT_PATH][7:0];
            `IDX_OOS_HIGH:  rd_byte = held_reg[CNT_OOS][15:8];
            `IDX_OOS_LOW:   rd_byte = held_reg[CNT_OOS][7:0];
            default:        hit = 1'b0;
        endcase
    end

    // Unmapped addresses answer with an error
    assign pslverr = acc & ~hit;

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // Configuration register; bit 7 is kept at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= `CFG_RESET;
        end else if (acc & pwrite & (idx == `IDX_CFG)) begin
            cfg_reg <= pwdata[7:0] & `CFG_WR_MASK;
        end
    end

    // ======================================================================
    // Latch timing
    assign period = cfg_reg.update_period_select
                  ? (e1 ? `E1_SHORT_FRAMES : `T1_SHORT_FRAMES)
                  : 14'(SEC_FRAMES);
    assign manual_go = cfg_reg.accumulation_mode_select
                     & cfg_reg.manual_latch_request & ~manual_prev_reg;
    assign periodic_go = ~cfg_reg.accumulation_mode_select & frame_tick
                       & (frame_cnt_reg >= period - 14'd1);
    assign latch_now = manual_go | periodic_go;

    // Manual request edge memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            manual_prev_reg <= 1'b0;
        end else begin
            manual_prev_reg <= cfg_reg.manual_latch_request;
        end
    end

    // Received frame counter for periodic latching
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt_reg <= 14'd0;
        end else if (periodic_go) begin
            frame_cnt_reg <= 14'd0;
        end else if (frame_tick) begin
            frame_cnt_reg <= frame_cnt_reg + 14'd1;
        end
    end

    // Status pulse on each periodic latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_pulse <= 1'b0;
        end else begin
            latch_pulse <= periodic_go;
        end
    end

    // ======================================================================
    // Line code events
    assign zrun_limit = rx_state.zero_subst_enable ? `ZRUN_SUBST : `ZRUN_NO_SUBST;
    assign zrun_ev = rx_bit_valid & ~rx_bit_mark & (zrun_reg == zrun_limit - 5'd1);
    assign bpv_ok  = bpv_strobe & ~(rx_state.zero_subst_enable & subst_codeword);
    assign cv_ev   = bpv_strobe & last_valid_reg & (bpv_polarity == last_pol_reg);

    // Zero run length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zrun_reg <= 5'd0;
        end else if (rx_bit_valid) begin
            zrun_reg <= (rx_bit_mark | zrun_ev) ? 5'd0 : zrun_reg + 5'd1;
        end
    end

    // Polarity of the last bipolar violation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_pol_reg   <= 1'b0;
            last_valid_reg <= 1'b0;
        end else if (bpv_strobe) begin
            last_pol_reg   <= bpv_polarity;
            last_valid_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Event selection per counter
    always_comb begin
        if (e1) begin
            ev[CNT_LINE] = cfg_reg.e1_violation_kind_select ? cv_ev : bpv_ok;
            ev[CNT_PATH] = crc_error & ~rx_state.fas_sync_lost
                         & ~rx_state.crc4_mf_sync_lost;
            ev[CNT_OOS]  = fas_word_error & ~sync_lost & ~rx_state.fas_search;
        end else begin
            ev[CNT_LINE] = bpv_ok | (cfg_reg.excess_zero_count_select & zrun_ev);
            ev[CNT_PATH] = ~sync_lost & (rx_state.esf_mode ? crc_error
                         : ft_error | (cfg_reg.fs_error_report_enable & fs_error));
            if (cfg_reg.oos_count_kind_select) begin
                ev[CNT_OOS] = multiframe_tick & sync_lost;
            end else begin
                ev[CNT_OOS] = ~sync_lost & (rx_state.esf_mode ? fps_error : ft_error);
            end
        end
    end

    // ======================================================================
    // Saturating counters and their latched copies
    for (genvar i = 0; i < 3; i++) begin : g_cnt
        // Count, or restart with the coincident event on a latch
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_reg[i] <= `CNT_RESET;
            end else if (latch_now) begin
                cnt_reg[i] <= {15'd0, ev[i]};
            end else if (ev[i] && cnt_reg[i] != `CNT_MAX) begin
                cnt_reg[i] <= cnt_reg[i] + 16'd1;
            end
        end

        // Readable copy
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                held_reg[i] <= `CNT_RESET;
            end else if (latch_now) begin
                held_reg[i] <= cnt_reg[i];
            end
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_manual_latch_copy: assert property (
        manual_go |=> held_reg[CNT_LINE] == $past(cnt_reg[CNT_LINE])
                  && held_reg[CNT_OOS] == $past(cnt_reg[CNT_OOS]))
        else $error("manual latch did not copy counts");

    a_latch_restart: assert property (
        latch_now |=> cnt_reg[CNT_PATH] == {15'd0, $past(ev[CNT_PATH])})
        else $error("counter not restarted on latch");

    a_line_saturate: assert property (
        cnt_reg[CNT_LINE] == `CNT_MAX && !latch_now |=> cnt_reg[CNT_LINE] == `CNT_MAX)
        else $error("line counter wrapped");

    a_path_t1_pause: assert property (
        !e1 && sync_lost && !latch_now |=> $stable(cnt_reg[CNT_PATH]))
        else $error("path counter moved during sync loss");

    a_oos_e1_search: assert property (
        e1 && rx_state.fas_search && !latch_now |=> $stable(cnt_reg[CNT_OOS]))
        else $error("FAS error counted during search");

    a_periodic_copy: assert property (
        periodic_go |=> latch_pulse && held_reg[CNT_PATH] == $past(cnt_reg[CNT_PATH]))
        else $error("periodic latch wrong");

    a_manual_no_auto: assert property (
        cfg_reg.accumulation_mode_select |=> !latch_pulse)
        else $error("periodic latch in manual mode");

    a_frame_bound: assert property (
        !cfg_reg.accumulation_mode_select && frame_cnt_reg < period
        |=> frame_cnt_reg < $past(period))
        else $error("frame counter past period");

    a_t1_bpv_count: assert property (
        !e1 && bpv_ok && !latch_now && cnt_reg[CNT_LINE] < `CNT_MAX
        |=> cnt_reg[CNT_LINE] == $past(cnt_reg[CNT_LINE]) + 16'd1)
        else $error("T1 violation not counted");

    // Pause and gating conditions
    a_manual_refused: assert property (
        cfg_reg.accumulation_mode_select && !cfg_reg.manual_latch_request
        |=> $stable(held_reg[CNT_LINE]) && $stable(held_reg[CNT_PATH]))
        else $error("counts latched without manual request");

    a_e1_path_pause: assert property (
        e1 && (rx_state.fas_sync_lost || rx_state.crc4_mf_sync_lost) && !latch_now
        |=> $stable(cnt_reg[CNT_PATH]))
        else $error("E1 path counter moved during sync loss");

    a_e1_oos_pause: assert property (
        e1 && sync_lost && !latch_now |=> $stable(cnt_reg[CNT_OOS]))
        else $error("E1 out-of-sync counter moved during sync loss");

    a_t1_fbit_pause: assert property (
        !e1 && !cfg_reg.oos_count_kind_select && sync_lost && !latch_now
        |=> $stable(cnt_reg[CNT_OOS]))
        else $error("framing-bit error counted during sync loss");

    a_t1_fs_gate: assert property (
        !e1 && !rx_state.esf_mode && !cfg_reg.fs_error_report_enable
        && !ft_error && !latch_now |=> $stable(cnt_reg[CNT_PATH]))
        else $error("Fs error counted while not enabled");

    a_subst_skip: assert property (
        !e1 && rx_state.zero_subst_enable && subst_codeword && !zrun_ev && !latch_now
        |=> $stable(cnt_reg[CNT_LINE]))
        else $error("substitution codeword counted");

    // Counting conditions
    a_t1_excess_zero: assert property (
        !e1 && cfg_reg.excess_zero_count_select && zrun_ev && !latch_now
        && cnt_reg[CNT_LINE] < `CNT_MAX
        |=> cnt_reg[CNT_LINE] == $past(cnt_reg[CNT_LINE]) + 16'd1)
        else $error("excess zero run not counted");

    a_e1_cv_only: assert property (
        e1 && cfg_reg.e1_violation_kind_select && !cv_ev && !latch_now
        |=> $stable(cnt_reg[CNT_LINE]))
        else $error("line counter moved without code violation");

    a_t1_mos_count: assert property (
        !e1 && cfg_reg.oos_count_kind_select && multiframe_tick && sync_lost
        && !latch_now && cnt_reg[CNT_OOS] < `CNT_MAX
        |=> cnt_reg[CNT_OOS] == $past(cnt_reg[CNT_OOS]) + 16'd1)
        else $error("out-of-sync multiframe not counted");

    c_manual_latch: cover property (manual_go);
    c_periodic_latch: cover property (latch_pulse);
    c_event_on_latch: cover property (latch_now && ev[CNT_LINE]);
    c_short_period: cover property (latch_pulse && cfg_reg.update_period_select);
    c_line_saturated: cover property (cnt_reg[CNT_LINE] == `CNT_MAX);

endmodule : line_path_error_counters

// ### bench/rx_framer_model.sv
// Model of the receive framer and line decoder feeding the counters.
// Assumes the bench calls pulse right after a rising edge of pclk.
`timescale 1ns/1ps

// ==========================================================================
// Framer model
module rx_framer_model (
    // Receive clock
    input  wire logic        pclk,
    // Strobes from bit 0: frame, multiframe, bit, mark, violation,
    // polarity, codeword, crc, ft, fs, fps, fas
    output logic      [11:0] st
);
    logic [1:0]  div_reg = 2'h0;
    logic [11:0] ev_reg  = 12'h000;

    // A frame every fourth clock, the line never stops
    always_ff @(posedge pclk) begin
        div_reg <= div_reg + 2'h1;
    end
    assign st = {ev_reg[11:1], div_reg == 2'h3};

    // Hold a strobe mask for n cycles, then idle at zero
    task automatic pulse(input logic [11:0] m, input int n);
        repeat (n) begin
            @(posedge pclk);
            ev_reg <= m;
        end
        @(posedge pclk);
        ev_reg <= 12'h000;
    endtask : pulse
endmodule : rx_framer_model

// ### bench/line_path_error_counters_bench.sv
// Self-checking bench for the line, path and out-of-sync counters.
// Assumes the framer model drives strobes; the bench drives APB and modes.
`timescale 1ns/1ps
`include "err_cnt_defines.svh"

// ==========================================================================
// Bench top
module line_path_error_counters_bench
    import err_cnt_pkg::*;
;
    localparam logic [11:0] BPV = 12'h010, POS = 12'h020, CW = 12'h040;
    localparam logic [11:0] CRC = 12'h080, FT = 12'h100, FS = 12'h200;
    localparam logic [11:0] FPS = 12'h400, FAS = 12'h800, ZERO = 12'h004;
    localparam logic [11:0] MARK = 12'h00C, MF = 12'h002;
    localparam logic [6:0]  E1 = 7'h40, ESF = 7'h20, SUB = 7'h10, RSL = 7'h08;
    localparam logic [6:0]  FASL = 7'h04, CRCL = 7'h02, SRCH = 7'h01;

    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [9:0]  paddr   = 10'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        latch_pulse;
    logic        err_v;
    logic [11:0] st;
    rx_state_s   rs      = 7'h00;
    logic [7:0]  cfg_v   = 8'h00;
    int          n_fail  = 0;
    int          tests_run = 0;

    // Clock, 25 ns period
    always #12.5 pclk = ~pclk;

    // Design and far side
    line_path_error_counters #(.SEC_FRAMES(20)) line_path_error_counters_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_state(rs),
        .frame_tick(st[0]), .multiframe_tick(st[1]), .rx_bit_valid(st[2]),
        .rx_bit_mark(st[3]), .bpv_strobe(st[4]), .bpv_polarity(st[5]),
        .subst_codeword(st[6]), .crc_error(st[7]), .ft_error(st[8]),
        .fs_error(st[9]), .fps_error(st[10]), .fas_word_error(st[11]),
        .latch_pulse
    );
    rx_framer_model rx_framer_model_inst (.pclk, .st);

    // ======================================================================
    // Shared tasks
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] r);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic ev(input logic [11:0] m, input int n);
        rx_framer_model_inst.pulse(m, n);
    endtask : ev

    task automatic setcfg(input logic [7:0] v);
        logic [31:0] r;
        cfg_v = v;
        apb(1'b1, `IDX_CFG, v, r); // Bit 7 always zero
    endtask : setcfg

    // Manual latch: bit 6 low then high; the trailing idle edge covers the wait
    task automatic lat;
        logic [31:0] r;
        apb(1'b1, `IDX_CFG, cfg_v, r);
        apb(1'b1, `IDX_CFG, cfg_v | 8'h40, r);
    endtask : lat

    // Read the three counts, high byte first
    task automatic cnt3(input logic [15:0] a, b, c);
        logic [31:0] h;
        logic [31:0] l;
        logic [7:0]  i;
        for (int k = 0; k < 3; k++) begin
            i = `IDX_LINE_HIGH + 8'(2 * k);
            apb(1'b0, i, 8'h00, h);
            apb(1'b0, i + 8'h01, 8'h00, l);
            chk("count", k == 0 ? a : k == 1 ? b : c, {h[23:0], l[7:0]});
        end
    endtask : cnt3

    task automatic wait_lp(output time t);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(negedge pclk);
            if (latch_pulse === 1'b1) break;
        end
        if (i == 3000) begin
            n_fail++;
            $display("FAIL latch_pulse expected 1 seen %b", latch_pulse);
        end
        t = $time;
        @(posedge pclk);
    endtask : wait_lp

    // ======================================================================
    // Scenarios
    task automatic t_reset;
        logic [31:0] r;
        apb(1'b1, `IDX_LINE_HIGH, 8'hFF, r);
        cnt3(16'h0000, 16'h0000, 16'h0000);
        apb(1'b0, `IDX_CFG, 8'h00, r);
        chk("cfg reset", 32'h0000_0000, r);
        chk("slverr idle", 32'h0000_0000, {31'h0, err_v});
        chk("pready", 32'h0000_0001, {31'h0, pready});
        apb(1'b0, 8'h40, 8'h00, r);
        chk("slverr", 32'h0000_0001, {31'h0, err_v});
        setcfg(8'h3B);
        apb(1'b0, `IDX_CFG, 8'h00, r);
        chk("cfg", 32'h0000_003B, r);
    endtask : t_reset

    task automatic t_line;
        rs <= 7'h00;
        setcfg(8'h10);
        lat();
        ev(BPV, 3);
        ev(BPV | CW, 2);
        rs <= RSL;
        ev(BPV, 1);
        lat();
        cnt3(16'h0006, 16'h0000, 16'h0000);
        rs <= SUB;
        setcfg(8'h11);
        lat();
        ev(BPV | CW, 2);
        ev(BPV, 1);
        ev(ZERO, 8);
        ev(ZERO, 7);
        ev(MARK, 1);
        rs <= 7'h00;
        ev(ZERO, 16);
        lat();
        cnt3(16'h0003, 16'h0000, 16'h0000);
        rs <= E1 | SUB | RSL;
        setcfg(8'h10);
        lat();
        ev(BPV, 2);
        ev(BPV | CW, 1);
        lat();
        cnt3(16'h0002, 16'h0000, 16'h0000);
        setcfg(8'h18);
        ev(BPV | POS, 1);
        lat();
        ev(BPV | POS, 1);
        ev(BPV, 1);
        ev(BPV, 1);
        ev(BPV | POS, 1);
        lat();
        cnt3(16'h0002, 16'h0000, 16'h0000);
    endtask : t_line

    task automatic t_path;
        rs <= ESF;
        setcfg(8'h10);
        lat();
        ev(CRC, 2);
        ev(FT, 1);
        ev(FPS, 3);
        lat();
        cnt3(16'h0000, 16'h0002, 16'h0003);
        rs <= 7'h00;
        ev(FT, 1);
        ev(FS, 1);
        setcfg(8'h14);
        ev(FS, 1);
        rs <= RSL;
        ev(FT, 1);
        setcfg(8'h12);
        lat();
        cnt3(16'h0000, 16'h0002, 16'h0001);
        ev(MF, 2);
        rs <= 7'h00;
        ev(MF, 1);
        ev(FT, 1);
        lat();
        cnt3(16'h0000, 16'h0001, 16'h0002);
        rs <= E1;
        setcfg(8'h10);
        lat();
        ev(CRC | FAS, 2);
        rs <= E1 | FASL;
        ev(CRC, 1);
        rs <= E1 | CRCL;
        ev(CRC, 1);
        rs <= E1 | SRCH;
        ev(FAS, 1);
        rs <= E1 | RSL;
        ev(FAS, 1);
        lat();
        cnt3(16'h0000, 16'h0002, 16'h0002);
    endtask : t_path

    task automatic t_sat;
        rs <= 7'h00;
        lat();
        ev(BPV, 258);
        lat();
        cnt3(16'h0102, 16'h0000, 16'h0000);
        ev(BPV, 65540);
        lat();
        cnt3(16'hFFFF, 16'h0000, 16'h0000);
    endtask : t_sat

    // Periodic latch: cycles between status pulses, counts of one period
    task automatic t_per(input logic [6:0] m, input logic [7:0] v, input int len);
        time t0;
        time t1;
        rs <= m;
        setcfg(v);
        wait_lp(t0);
        ev(BPV, 5);
        wait_lp(t1);
        chk("period", 32'(len), 32'((t1 - t0) / 25));
        cnt3(16'h0005, 16'h0000, 16'h0000);
        lat();
        cnt3(16'h0005, 16'h0000, 16'h0000);
    endtask : t_per

    // ======================================================================
    // Main sequence and watchdog
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_line();
        t_path();
        t_sat();
        t_per(7'h00, 8'h20, 1332);
        t_per(E1, 8'h20, 2000);
        t_per(7'h00, 8'h00, 80);
        tally_and_finish();
    end

    initial begin
        repeat (90000) @(posedge pclk);
        n_fail++;
        tally_and_finish();
    end
endmodule : line_path_error_counters_bench
